// ===== rtl/spc_pkg.sv
package spc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_MC_CTRL   = 16'hfff3;
	localparam logic [15:0] IDX_STATUS    = 16'hfff4;
	localparam logic [15:0] IDX_PORT_CTRL = 16'hfff6;
	localparam logic [15:0] IDX_COUNT     = 16'hfffb;

	// Port control bit positions
	localparam int unsigned CR_INT_CLK = 0;
	localparam int unsigned CR_CONT    = 1;
	localparam int unsigned CR_INT_FS  = 2;

	// Multichannel control bit positions
	localparam int unsigned MC_CNT_MODE = 0;
	localparam int unsigned MC_HALT     = 1;
	localparam int unsigned MC_IRQ_SEL  = 2;
	localparam int unsigned MC_MULTI    = 3;
	localparam int unsigned MC_BYTE     = 4;

	// Port status bit positions
	localparam int unsigned ST_PRESCALE_ENABLE   = 8;
	localparam int unsigned ST_CLK_OUT = 9;
	localparam int unsigned ST_SHIFT_CLK_CONFIG_BIT    = 10;
	localparam int unsigned ST_FSN     = 11;
	localparam int unsigned ST_FLAG    = 12;
	localparam int unsigned ST_FS_TXQ  = 13;
	localparam int unsigned ST_STABLE  = 14;

	// Values after reset
	localparam logic [2:0]  CR_RST    = 3'h0;
	localparam logic [4:0]  MC_RST    = 5'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// Multichannel frame spacing in bit clocks, and channel count
	localparam logic [4:0] SLOT_16BIT  = 5'h12;
	localparam logic [4:0] SLOT_8BIT   = 5'h0a;
	localparam int unsigned MC_CHANNELS = 4;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_SLOT = 2'b10
	} spc_seq_e;
endpackage : spc_pkg

// ===== rtl/spc_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for the shift clock pin
module spc_sync (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// Only the second stage is visible outside
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : spc_sync

// ===== rtl/spc_div8.sv
`timescale 1ns/100ps
// One 8-bit prescaler stage: load from its reload byte or step down
module spc_div8 #(
	parameter int unsigned W = 8
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         load,
	input  wire logic         dec,
	input  wire logic [W-1:0] load_val,
	output logic      [W-1:0] cnt
);
	// Decrement wraps 0 to all ones, which gives the borrow chain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
		end else if (load) begin
			cnt <= load_val;
		end else if (dec) begin
			cnt <= cnt - W'(1);
		end
	end
endmodule : spc_div8

// ===== rtl/spc_prescaler.sv
`timescale 1ns/100ps
// How it works
// - Counter mode chains both bytes, counting down
// - Counter mode: no clock or sync scaling
// - Counter input is cpu clock or pin
// - Count readable anytime; halt freezes it
// - Zero reached sets the frame zero flag
// - At zero reload from buffer, keep counting
// - Writing one clears flag; zero ignored
// - Prescale register: frame high, shift low
// - Internal clock: half or full cpu clock
// - External clock: pin or cpu clock
// - Base features need only port control
// - Dividers run only with prescale enable
// - Clocks stable after first divider reload
// - 16-bit multichannel syncs 18 bit clocks apart
// - 8-bit multichannel syncs 10 bit clocks apart
// - Frame divider needs prescale enable set
// - Continuous mode disables multichannel options
// - Queue-rate mode: sync per shifted word
// - Shift clock is cpu clock over 2(N+1)
// - Frame rate is input over 2(N+1)
// - Counter interrupt replaces transmit interrupt
// - Halt defaults to counting; one stops
module spc_prescaler #(
	parameter int unsigned CHANNELS = spc_pkg::MC_CHANNELS
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        tx_shift_clock_i,
	output logic             tx_shift_clock_o,
	output logic             tx_shift_clock_oe,
	output logic             tx_frame_sync_o,
	output logic             tx_frame_sync_oe,
	input  wire logic        tx_word_shift,
	output logic             tx_interrupt
);
	logic [2:0]  cr_q;
	logic [4:0]  mc_q;
	logic        prescale_enable_q, prescale_enable_prev_q, clk_out_q, shift_clk_config_bit_q, fsn_q;
	logic        flag_q, fs_txq_q, stable_q;
	logic [15:0] reload_q;
	logic        wr_q;
	logic [15:0] idx_q;
	logic [15:0] rd_val;
	logic [7:0]  lo_cnt, hi_cnt;
	logic        lo_load, lo_dec, hi_load, hi_dec;
	logic        ext_s, ext_prev_q, ext_rise;
	logic        half_q, div_clk_q, shift_prev_q, shift_clk_d;
	logic        frame_clk_q, bit_rise, frame_evt;
	logic        cm, run, cnt_tick, start, cnt_zero_evt, flag_set;
	logic        multi_on, fs_req, fs_hold_q, fs_hold_d;
	logic [4:0]  slot_len, slot_q;
	logic [2:0]  chan_q;
	spc_pkg::spc_seq_e seq_q;
	wire         ap = hsel & hready & htrans[1];
	wire  [15:0] count = {hi_cnt, lo_cnt};
	wire         wr_cr = wr_q && idx_q == spc_pkg::IDX_PORT_CTRL;
	wire         wr_mc = wr_q && idx_q == spc_pkg::IDX_MC_CTRL;
	wire         wr_st = wr_q && idx_q == spc_pkg::IDX_STATUS;
	wire         wr_ct = wr_q && idx_q == spc_pkg::IDX_COUNT;

	// Address phase capture; zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q      <= 1'b0;
			idx_q     <= 16'h0000;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			wr_q      <= ap & hwrite;
			idx_q     <= haddr[17:2];
			hrdata    <= (ap & ~hwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read mux; count reads the live counters, unmapped reads as zero
	always_comb begin
		rd_val = 16'h0000;
		case (haddr[17:2])
			spc_pkg::IDX_PORT_CTRL: rd_val = {13'h0000, cr_q};
			spc_pkg::IDX_MC_CTRL:   rd_val = {11'h000, mc_q};
			spc_pkg::IDX_COUNT:     rd_val = count;
			spc_pkg::IDX_STATUS: begin
				rd_val[spc_pkg::ST_PRESCALE_ENABLE]   = prescale_enable_q;
				rd_val[spc_pkg::ST_CLK_OUT] = clk_out_q;
				rd_val[spc_pkg::ST_SHIFT_CLK_CONFIG_BIT]    = shift_clk_config_bit_q;
				rd_val[spc_pkg::ST_FSN]     = fsn_q;
				rd_val[spc_pkg::ST_FLAG]    = flag_q;
				rd_val[spc_pkg::ST_FS_TXQ]  = fs_txq_q;
				rd_val[spc_pkg::ST_STABLE]  = stable_q;
			end
			default: rd_val = 16'h0000;
		endcase
	end

	// Control registers; hsize is ignored, whole words only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cr_q      <= spc_pkg::CR_RST;
			mc_q      <= spc_pkg::MC_RST;
			prescale_enable_q   <= 1'b0;
			clk_out_q <= 1'b0;
			shift_clk_config_bit_q    <= 1'b0;
			fsn_q     <= 1'b0;
			fs_txq_q  <= 1'b0;
			reload_q  <= spc_pkg::COUNT_RST;
		end else begin
			if (wr_cr) cr_q <= hwdata[2:0];
			if (wr_mc) mc_q <= hwdata[4:0];
			if (wr_ct) reload_q <= hwdata[15:0];
			if (wr_st) begin
				prescale_enable_q   <= hwdata[spc_pkg::ST_PRESCALE_ENABLE];
				clk_out_q <= hwdata[spc_pkg::ST_CLK_OUT];
				shift_clk_config_bit_q    <= hwdata[spc_pkg::ST_SHIFT_CLK_CONFIG_BIT];
				fsn_q     <= hwdata[spc_pkg::ST_FSN];
				fs_txq_q  <= hwdata[spc_pkg::ST_FS_TXQ];
			end
		end
	end

	// Flag: set wins over a same-cycle write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1;
		end else if (wr_st && hwdata[spc_pkg::ST_FLAG]) begin
			flag_q <= 1'b0;
		end
	end

	spc_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (tx_shift_clock_i),
		.q       (ext_s)
	);

	// Clock edges: pin edge, half-rate toggle, divided shift clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_prev_q   <= 1'b0;
			half_q       <= 1'b0;
			div_clk_q    <= 1'b0;
			shift_prev_q <= 1'b0;
			frame_clk_q  <= 1'b0;
			prescale_enable_prev_q <= 1'b0;
		end else begin
			ext_prev_q   <= ext_s;
			half_q       <= ~half_q;
			shift_prev_q <= shift_clk_d;
			prescale_enable_prev_q <= prescale_enable_q;
			if (!prescale_enable_q || cm) begin
				div_clk_q   <= 1'b0;
				frame_clk_q <= 1'b0;
			end else begin
				if (lo_load && !start) div_clk_q <= ~div_clk_q;
				if (hi_load && !start) frame_clk_q <= ~frame_clk_q;
			end
		end
	end

	assign ext_rise = ext_s & ~ext_prev_q;
	assign cm       = mc_q[spc_pkg::MC_CNT_MODE];
	assign start    = prescale_enable_q & ~prescale_enable_prev_q;
	// Undivided half rate whenever the prescaler is not scaling
	assign shift_clk_d = (prescale_enable_q && !cm) ? div_clk_q : half_q;
	assign bit_rise = cr_q[spc_pkg::CR_INT_CLK] ? (shift_clk_d & ~shift_prev_q) : ext_rise;
	// Counter input selection
	assign cnt_tick = cr_q[spc_pkg::CR_INT_CLK] ? (clk_out_q ? half_q : 1'b1)
		: (clk_out_q ? ext_rise : 1'b1);
	assign run = prescale_enable_q & ~mc_q[spc_pkg::MC_HALT] & cnt_tick;
	assign frame_evt = prescale_enable_q & ~cm & ~start & hi_load & ~frame_clk_q;
	assign cnt_zero_evt = cm & run & ~start & lo_dec & ~hi_dec & lo_cnt == 8'h01 &
		hi_cnt == 8'h00;
	assign flag_set = cm ? cnt_zero_evt : (prescale_enable_q & ~start & hi_load);

	// Divider steering, normal and chained counter mode
	always_comb begin
		lo_load = 1'b0;
		lo_dec  = 1'b0;
		hi_load = 1'b0;
		hi_dec  = 1'b0;
		if (start) begin
			lo_load = 1'b1;
			hi_load = 1'b1;
		end else if (prescale_enable_q) begin
			if (cm) begin
				if (run && count == 16'h0000) begin
					lo_load = 1'b1;
					hi_load = 1'b1;
				end else if (run) begin
					lo_dec = 1'b1;
					hi_dec = lo_cnt == 8'h00;
				end
			end else begin
				lo_load = lo_cnt == 8'h00;
				lo_dec  = lo_cnt != 8'h00;
				if (bit_rise) begin
					hi_load = hi_cnt == 8'h00;
					hi_dec  = hi_cnt != 8'h00;
				end
			end
		end
	end

	spc_div8 u_shift_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.load     (lo_load),
		.dec      (lo_dec),
		.load_val (reload_q[7:0]),
		.cnt      (lo_cnt)
	);

	spc_div8 u_frame_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.load     (hi_load),
		.dec      (hi_dec),
		.load_val (reload_q[15:8]),
		.cnt      (hi_cnt)
	);

	// Stability tracks the first reload after enabling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stable_q <= 1'b0;
		end else if (!prescale_enable_q) begin
			stable_q <= 1'b0;
		end else if (!start && (lo_load || hi_load)) begin
			stable_q <= 1'b1;
		end
	end

	// Multichannel sequencer; continuous mode masks it out
	assign multi_on = mc_q[spc_pkg::MC_MULTI] & ~cr_q[spc_pkg::CR_CONT];
	assign slot_len = mc_q[spc_pkg::MC_BYTE] ? spc_pkg::SLOT_8BIT
		: spc_pkg::SLOT_16BIT;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_q  <= spc_pkg::SEQ_IDLE;
			slot_q <= 5'h00;
			chan_q <= 3'h0;
		end else begin
			case (seq_q)
				spc_pkg::SEQ_IDLE: begin
					if (multi_on && frame_evt) begin
						seq_q  <= spc_pkg::SEQ_SLOT;
						slot_q <= slot_len - 5'h01;
						chan_q <= 3'h1;
					end
				end
				spc_pkg::SEQ_SLOT: begin
					if (!multi_on || !prescale_enable_q) begin
						seq_q <= spc_pkg::SEQ_IDLE;
					end else if (bit_rise && slot_q != 5'h00) begin
						slot_q <= slot_q - 5'h01;
					end else if (bit_rise) begin
						slot_q <= slot_len - 5'h01;
						chan_q <= chan_q + 3'h1;
						if (chan_q == 3'(CHANNELS - 1)) seq_q <= spc_pkg::SEQ_IDLE;
					end
				end
				default: seq_q <= spc_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Frame sync request: queue rate in legacy or counter use
	always_comb begin
		if (fs_txq_q || !prescale_enable_q || cm) begin
			fs_req = tx_word_shift;
		end else if (multi_on) begin
			fs_req = (seq_q == spc_pkg::SEQ_IDLE && frame_evt) ||
				(seq_q == spc_pkg::SEQ_SLOT && bit_rise && slot_q == 5'h00 &&
				prescale_enable_q);
		end else begin
			fs_req = frame_evt;
		end
		fs_hold_d = fs_req | (fs_hold_q & ~bit_rise);
	end

	// Pins and interrupt, all registered; pulse lasts one bit clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs_hold_q         <= 1'b0;
			tx_shift_clock_o  <= 1'b0;
			tx_shift_clock_oe <= 1'b0;
			tx_frame_sync_o   <= 1'b0;
			tx_frame_sync_oe  <= 1'b0;
			tx_interrupt      <= 1'b0;
		end else begin
			fs_hold_q         <= fs_hold_d;
			tx_shift_clock_o  <= shift_clk_d ^ shift_clk_config_bit_q;
			tx_shift_clock_oe <= cr_q[spc_pkg::CR_INT_CLK];
			tx_frame_sync_o   <= fs_hold_d ^ fsn_q;
			tx_frame_sync_oe  <= cr_q[spc_pkg::CR_INT_FS];
			tx_interrupt      <= mc_q[spc_pkg::MC_IRQ_SEL] ? cnt_zero_evt
				: tx_word_shift;
		end
	end

	// Checks
	sequence s_cnt_wrap;
		cm && run && !start && count == 16'h0000;
	endsequence

	chk_cnt_reload: assert property (@(posedge hclk) disable iff (!hresetn)
		s_cnt_wrap |=> count == $past(reload_q))
		else $error("counter did not reload at zero");

	chk_cnt_down: assert property (@(posedge hclk) disable iff (!hresetn)
		cm && run && !start && count != 16'h0000 |=> count == $past(count) - 16'h0001)
		else $error("counter did not step down by one");

	chk_halt_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		cm && mc_q[spc_pkg::MC_HALT] && !start |=> $stable(count))
		else $error("counter moved while halted");

	chk_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!prescale_enable_q |=> $stable(count))
		else $error("dividers moved without enable");

	chk_flag_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		cnt_zero_evt |=> flag_q && count == 16'h0000)
		else $error("zero reached without flag");

	chk_flag_w1c: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_st && hwdata[spc_pkg::ST_FLAG] && !flag_set |=> !flag_q)
		else $error("flag not cleared by write one");

	chk_no_scale: assert property (@(posedge hclk) disable iff (!hresetn)
		cm ##1 cm |-> tx_shift_clock_o == ($past(half_q) ^ $past(shift_clk_config_bit_q)))
		else $error("shift clock scaled in counter mode");

	chk_irq_route: assert property (@(posedge hclk) disable iff (!hresetn)
		mc_q[spc_pkg::MC_IRQ_SEL] && cnt_zero_evt |=> tx_interrupt)
		else $error("counter interrupt missing");

	chk_cont_mask: assert property (@(posedge hclk) disable iff (!hresetn)
		cr_q[spc_pkg::CR_CONT] |=> seq_q == spc_pkg::SEQ_IDLE)
		else $error("multichannel active in continuous mode");
endmodule : spc_prescaler

// ===== verification/spc_codec_model.sv
`timescale 1ns/100ps
// Codec side: supplies shift clock bursts on the pin
module spc_codec_model (
	output logic clk_pin
);
	// Clock stands low between bursts, as a slave codec frame ends
	initial clk_pin = 1'b0;

	// Slow enough that the pin synchroniser sees every edge
	task automatic clocks(input int n);
		// Pin edges fall between bus clock edges, never on them
		#10;
		repeat (n) begin
			#150 clk_pin = 1'b1;
			#150 clk_pin = 1'b0;
		end
	endtask : clocks
endmodule : spc_codec_model

// ===== verification/serial_port_prescaler_counter_test.sv
`timescale 1ns/100ps
// Register level test of the prescaler and counter
module serial_port_prescaler_counter_test;
	localparam logic [31:0] EN  = 32'h1 << spc_pkg::ST_PRESCALE_ENABLE;
	localparam logic [31:0] OS  = 32'h1 << spc_pkg::ST_CLK_OUT;
	localparam logic [31:0] FLG = 32'h1 << spc_pkg::ST_FLAG;
	localparam logic [31:0] CM  = 32'h1 << spc_pkg::MC_CNT_MODE;
	localparam logic [31:0] HLT = 32'h1 << spc_pkg::MC_HALT;
	localparam logic [31:0] IRQ = 32'h1 << spc_pkg::MC_IRQ_SEL;
	localparam logic [31:0] CK  = 32'h1 << spc_pkg::ST_SHIFT_CLK_CONFIG_BIT;
	localparam logic [31:0] TXQ = 32'h1 << spc_pkg::ST_FS_TXQ;
	localparam logic [31:0] STB = 32'h1 << spc_pkg::ST_STABLE;
	localparam logic [31:0] MUL = 32'h1 << spc_pkg::MC_MULTI;
	localparam logic [31:0] BYT = 32'h1 << spc_pkg::MC_BYTE;
	localparam logic [15:0] CT  = spc_pkg::IDX_COUNT;
	localparam logic [15:0] ST  = spc_pkg::IDX_STATUS;
	localparam logic [15:0] MC  = spc_pkg::IDX_MC_CTRL;
	localparam logic [15:0] PC  = spc_pkg::IDX_PORT_CTRL;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        word_shift = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        sck_o;
	logic        sck_oe;
	logic        codec_clk;
	logic        fs_o;
	logic        fs_oe;
	logic        tx_interrupt;
	wire         sck_pin = sck_oe ? sck_o : codec_clk;
	logic [31:0] rd;
	logic [31:0] a;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          irqs = 0;
	int          irq0;
	int          fs0;
	int          sck_at = 0;
	int          sck_gap = 0;
	int          fs_at = 0;
	int          fs_gap = 0;
	int          fs_cnt = 0;
	logic        sck_q = 1'b0;
	logic        fs_q = 1'b0;

	// 20 MHz bus clock
	always #25 hclk = ~hclk;

	spc_prescaler i_dut (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (3'h2),
		.hwdata            (hwdata),
		.hready            (hreadyout),
		.hrdata            (hrdata),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.tx_shift_clock_i  (sck_pin),
		.tx_shift_clock_o  (sck_o),
		.tx_shift_clock_oe (sck_oe),
		.tx_frame_sync_o   (fs_o),
		.tx_frame_sync_oe  (fs_oe),
		.tx_word_shift     (word_shift),
		.tx_interrupt      (tx_interrupt)
	);

	spc_codec_model i_codec (
		.clk_pin (codec_clk)
	);

	// Interrupt pulses and pin edges are counted, cycle limit cuts a hang short
	always @(posedge hclk) begin
		cycles++;
		if (tx_interrupt === 1'b1)
			irqs++;
		// Gaps in bus clock cycles between rising edges of the driven pins
		if (sck_o === 1'b1 && sck_q === 1'b0) begin
			sck_gap = cycles - sck_at;
			sck_at  = cycles;
		end
		if (fs_o === 1'b1 && fs_q === 1'b0) begin
			fs_gap = cycles - fs_at;
			fs_at  = cycles;
			fs_cnt++;
		end
		sck_q = sck_o;
		fs_q  = fs_o;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	// One single word transfer; waits for hready in both phases
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {14'h0, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// Count over two cycles for a given tick source
	task automatic rate(input logic [31:0] e);
		bus(0, CT, 0);
		a = rd;
		bus(0, CT, 0);
		chk("count step", e, a - rd);
	endtask : rate

	initial begin
		cyc(5);
		hresetn <= 1'b1;
		cyc(2);
		bus(0, CT, 0);
		chk("count reset", 32'h0, rd);
		bus(1, CT, 32'h0105);
		bus(0, CT, 0);
		chk("count idle", 32'h0, rd);
		bus(1, 16'h0100, 32'hffff);
		bus(0, 16'h0100, 0);
		chk("unmapped", 32'h0, rd);
		// Pin clocked counter, byte borrow and halt
		bus(1, MC, CM);
		bus(1, ST, EN | OS);
		cyc(2);
		bus(0, CT, 0);
		chk("count load", 32'h0105, rd);
		i_codec.clocks(6);
		cyc(5);
		bus(0, CT, 0);
		chk("count pin", 32'h00ff, rd);
		bus(1, MC, CM | HLT);
		i_codec.clocks(3);
		cyc(5);
		bus(0, CT, 0);
		chk("count halt", 32'h00ff, rd);
		// Zero flag, counter interrupt and reload
		bus(1, ST, 0);
		bus(1, CT, 32'h0002);
		bus(1, MC, CM | IRQ);
		bus(1, ST, EN | OS);
		cyc(2);
		irq0 = irqs;
		i_codec.clocks(2);
		cyc(5);
		bus(0, CT, 0);
		chk("count zero", 32'h0, rd);
		bus(0, ST, 0);
		chk("flag set", FLG, rd & FLG);
		chk("irq", irq0 + 1, irqs);
		i_codec.clocks(1);
		cyc(5);
		bus(0, CT, 0);
		chk("reload", 32'h0002, rd);
		bus(1, ST, EN | OS);
		bus(0, ST, 0);
		chk("flag kept", FLG, rd & FLG);
		bus(1, ST, EN | OS | FLG);
		bus(0, ST, 0);
		chk("flag clear", 32'h0, rd & FLG);
		// Word shift gives the transmit interrupt when not redirected
		bus(1, MC, CM);
		word_shift <= 1'b1;
		cyc(1);
		word_shift <= 1'b0;
		cyc(3);
		chk("tx irq", irq0 + 2, irqs);
		// Internal tick sources
		bus(1, ST, 0);
		bus(1, CT, 32'hffff);
		bus(1, PC, 32'h1);
		bus(1, ST, EN | OS);
		cyc(3);
		rate(32'h1);
		bus(1, ST, EN);
		cyc(2);
		rate(32'h2);
		bus(1, PC, 32'h0);
		cyc(2);
		rate(32'h2);
		// Normal mode: divided shift clock, frame sync and stability
		bus(1, ST, 0);
		bus(1, MC, 0);
		bus(1, CT, 32'h0102);
		bus(1, PC, 32'h5);
		bus(1, ST, CK);
		cyc(10);
		bus(1, ST, EN | CK);
		bus(0, ST, 0);
		chk("stable early", 32'h0, rd & STB);
		cyc(80);
		bus(0, ST, 0);
		chk("stable", STB, rd & STB);
		chk("sck period", 32'h6, sck_gap);
		chk("fs period", 32'h18, fs_gap);
		chk("pin drive", 32'h3, {30'h0, sck_oe, fs_oe});
		// Multichannel spacing, frame long enough for four syncs
		bus(1, ST, 0);
		bus(1, CT, 32'h2300);
		bus(1, MC, MUL);
		bus(1, ST, EN);
		cyc(400);
		chk("slot 16", 32'h24, fs_gap);
		bus(1, ST, 0);
		bus(1, CT, 32'h1300);
		bus(1, MC, MUL | BYT);
		bus(1, ST, EN);
		cyc(200);
		chk("slot 8", 32'h14, fs_gap);
		// Continuous mode leaves only the divided frame rate
		bus(1, PC, 32'h7);
		cyc(400);
		chk("cont rate", 32'h50, fs_gap);
		// One sync per word leaving the queue
		bus(1, ST, EN | TXQ);
		cyc(20);
		fs0 = fs_cnt;
		word_shift <= 1'b1;
		cyc(1);
		word_shift <= 1'b0;
		cyc(20);
		chk("sync per word", fs0 + 1, fs_cnt);
		complete_run();
	end
endmodule : serial_port_prescaler_counter_test
